//--- logic/isc_cfg.svh
// Offsets, field positions, reset values and timing counts of the
// instrument state command handler. Assumes a 50 MHz system clock.
// Functional notes
// - Options query streams the ASCII capability token string
// - Local mode allows only measurement requests
// - Recall takes location 1 to 40
// - Recall loads current, voltage and both limits
// - Recall restores language and output state only for locations written by Save
// - Edit-saved locations keep output and language
// - Reset zeroes levels, maximises limits, output off
// - Reset clears latched protection faults
// - Save copies four levels into location
// - Save also stores language and output state
// - Unknown header sets command error bit 5
// - Event status read returns then clears
// - Power-on bit after reset, completion bit
// - Event enable query returns written mask
// - Service mask selects summaries for service request
// - Status byte query returns weighted bit sum
// - Armed trigger moves voltage to trigger level
// - Self-test answers 0 pass, 1 fail
// - Completion query answers ASCII 1 when idle
// - Completion command arms event bit 0
// - List index selects location for list writes
// - Enabled event bits ORed into status bit 5
// - Enabled status bits ORed into bit 6
// - Serial poll clears service request, summary stays
`ifndef ISC_CFG_SVH
`define ISC_CFG_SVH
`define ISC_A_CMD 8'h00
`define ISC_A_RESP 8'h04
`define ISC_A_STAT 8'h08
`define ISC_A_LVL 8'h0C
`define ISC_A_LIM 8'h10
`define ISC_A_STB 8'h14
`define ISC_A_TRIG 8'h18
`define ISC_NLOC 40
`define ISC_ESR_PON 7
`define ISC_ESR_CME 5
`define ISC_ESR_EXE 4
`define ISC_ESR_OPC 0
`define ISC_STB_OPER 7
`define ISC_STB_MSS 6
`define ISC_STB_ESB 5
`define ISC_STB_MAV 4
`define ISC_STB_QUES 3
`define ISC_ESR_RST 8'h80
`define ISC_SRE_WMASK 8'hBF
`define ISC_LVL_RST 16'h0000
`define ISC_OCP_MAX 16'hFFFF
`define ISC_OVP_MAX 16'hFFFF
`define ISC_ASCII_ONE 16'h0031
`define ISC_OPT_LEN 4'hF
`define ISC_SETTLE_US 100
`define ISC_CLK_MHZ 50
`define ISC_SETTLE_CYC (`ISC_SETTLE_US * `ISC_CLK_MHZ)
`endif

//--- logic/isc_pkg.sv
// Types of the instrument state command handler: command codes and
// self-test states. Constants live in isc_cfg.svh.
package isc_pkg;
  typedef enum logic [7:0] {
    OP_SETCURR = 8'h01, OP_SETVOLT = 8'h02, OP_SETOCP = 8'h03,
    OP_SETOVP = 8'h04, OP_SETTRIGV = 8'h05, OP_SETOUT = 8'h06,
    OP_SETLANG = 8'h07, OP_LIST_IND = 8'h08, OP_LIST_CURR = 8'h09,
    OP_LIST_VOLT = 8'h0A, OP_MEASC = 8'h0B, OP_MEASV = 8'h0C,
    OP_INIT = 8'h0D, OP_CLS = 8'h10, OP_ESE = 8'h11, OP_ESEQ = 8'h12,
    OP_ESRQ = 8'h13, OP_OPC = 8'h14, OP_OPCQ = 8'h15, OP_OPT = 8'h16,
    OP_RCL = 8'h17, OP_RST = 8'h18, OP_SAV = 8'h19, OP_SRE = 8'h1A,
    OP_SREQ = 8'h1B, OP_STBQ = 8'h1C, OP_TRG = 8'h1D, OP_TST = 8'h1E
  } isc_op_t;
  typedef enum logic [1:0] {
    TS_IDLE = 2'b01,
    TS_SCAN = 2'b10
  } isc_ts_t;
endpackage

//--- logic/isc_mask_or.sv
// Masked OR summary of a status register.
// Assumes bits and mask are from the same clock domain.
`timescale 1ns/10ps
module isc_mask_or #(
  parameter int W = 8
) (
  input wire logic [W-1:0] bits,
  input wire logic [W-1:0] mask,
  output logic any
);
  assign any = |(bits & mask);
endmodule

//--- logic/isc_cmd_handler.sv
// Instrument state command handler: AHB-Lite slave, command decode,
// setup store, status summaries, trigger and self-test.
// Assumes a single-master AHB-Lite bus and synchronous inputs on hclk.
`timescale 1ns/10ps
`include "isc_cfg.svh"
module isc_cmd_handler #(
  parameter int SETTLE_CYC = `ISC_SETTLE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic remote_mode,
  input wire logic ren,
  input wire logic serial_poll,
  input wire logic ovp_trip,
  input wire logic ocp_trip,
  input wire logic ques_summary,
  input wire logic oper_summary,
  output logic [15:0] curr_set,
  output logic [15:0] volt_set,
  output logic [15:0] ocp_lim,
  output logic [15:0] ovp_lim,
  output logic out_on,
  output logic lang_sel,
  output logic ovp_fault,
  output logic ocp_fault,
  output logic trig_armed,
  output logic srq,
  output logic [7:0] poll_byte
);
  localparam int NLOC = `ISC_NLOC;
  logic ahb_take, wr_pend_r, cmd_wr, resp_pop, known, needs_loc;
  logic loc_ok, allowed, go, cme_set, exe_set, busy, level_chg;
  logic esb, mss, mss_d_r, rqs_r, opc_armed_r, opc_done, opcq_pend_r;
  logic opt_act_r, ts_done, ts_bad, ts_fail_r, resp_v_r;
  logic [7:0] wa_r, esr_r, ese_r, sre_r, stb_base, stb, esr_set;
  logic [15:0] arg, trig_v_r, resp_r, settle_r;
  logic [5:0] li, sel_r, ts_idx_r;
  logic [3:0] opt_idx_r;
  isc_pkg::isc_op_t op;
  isc_pkg::isc_ts_t ts_r;
  logic [15:0] mem_c [NLOC];
  logic [15:0] mem_v [NLOC];
  logic [15:0] mem_op [NLOC];
  logic [15:0] mem_oc [NLOC];
  logic mem_lang [NLOC];
  logic mem_out [NLOC];
  logic mem_sav [NLOC];
  logic mem_par [NLOC];

  function automatic logic [15:0] opt_char(input logic [3:0] i);
    unique case (i)
      4'h0: opt_char = 16'h0043;
      4'h1: opt_char = 16'h0041;
      4'h2: opt_char = 16'h004C;
      4'h4: opt_char = 16'h0052;
      4'h5: opt_char = 16'h004C;
      4'h6: opt_char = 16'h0033;
      4'h8: opt_char = 16'h004D;
      4'h9: opt_char = 16'h0034;
      4'hA: opt_char = 16'h0030;
      4'hC: opt_char = 16'h0044;
      4'hD: opt_char = 16'h0031;
      4'hE: opt_char = 16'h0036;
      default: opt_char = 16'h002C;
    endcase
  endfunction

  function automatic logic par4(input logic [15:0] a, input logic [15:0] b,
                                input logic [15:0] c, input logic [15:0] d);
    par4 = ^{a, b, c, d};
  endfunction

  // Zero-wait slave; writes act in the data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ahb_take = hsel & htrans[1] & hready;
  assign resp_pop = ahb_take & ~hwrite & (haddr[7:0] == `ISC_A_RESP);
  assign cmd_wr = wr_pend_r & (wa_r == `ISC_A_CMD);
  assign op = isc_pkg::isc_op_t'(hwdata[7:0]);
  assign arg = hwdata[23:8];
  assign li = 6'(arg - 16'h0001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wa_r <= 8'h00;
    end else begin
      wr_pend_r <= ahb_take & hwrite;
      wa_r <= haddr[7:0];
    end
  end

  always_comb begin
    known = 1'b1;
    case (op)
      isc_pkg::OP_SETCURR, isc_pkg::OP_SETVOLT, isc_pkg::OP_SETOCP,
      isc_pkg::OP_SETOVP, isc_pkg::OP_SETTRIGV, isc_pkg::OP_SETOUT,
      isc_pkg::OP_SETLANG, isc_pkg::OP_LIST_IND, isc_pkg::OP_LIST_CURR,
      isc_pkg::OP_LIST_VOLT, isc_pkg::OP_MEASC, isc_pkg::OP_MEASV,
      isc_pkg::OP_INIT, isc_pkg::OP_CLS, isc_pkg::OP_ESE,
      isc_pkg::OP_ESEQ, isc_pkg::OP_ESRQ, isc_pkg::OP_OPC,
      isc_pkg::OP_OPCQ, isc_pkg::OP_OPT, isc_pkg::OP_RCL,
      isc_pkg::OP_RST, isc_pkg::OP_SAV, isc_pkg::OP_SRE,
      isc_pkg::OP_SREQ, isc_pkg::OP_STBQ, isc_pkg::OP_TRG,
      isc_pkg::OP_TST: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  assign needs_loc = (op == isc_pkg::OP_RCL) | (op == isc_pkg::OP_SAV) |
                     (op == isc_pkg::OP_LIST_IND);
  assign loc_ok = (arg >= 16'h0001) & (arg <= 16'(NLOC));
  // Measurements pass in local mode, all else needs remote and enable
  assign allowed = (remote_mode & ren) | (op == isc_pkg::OP_MEASC) |
                   (op == isc_pkg::OP_MEASV);
  assign go = cmd_wr & known & allowed & (~needs_loc | loc_ok);
  assign cme_set = cmd_wr & ~known;
  assign exe_set = cmd_wr & known &
                   (~allowed | (needs_loc & ~loc_ok));
  assign level_chg = go & ((op == isc_pkg::OP_SETCURR) |
    (op == isc_pkg::OP_SETVOLT) | (op == isc_pkg::OP_SETOCP) |
    (op == isc_pkg::OP_SETOVP) | (op == isc_pkg::OP_SETOUT) |
    (op == isc_pkg::OP_RCL) | (op == isc_pkg::OP_RST) |
    ((op == isc_pkg::OP_TRG) & trig_armed));

  // Active settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      curr_set <= `ISC_LVL_RST;
      volt_set <= `ISC_LVL_RST;
      ocp_lim <= `ISC_OCP_MAX;
      ovp_lim <= `ISC_OVP_MAX;
      out_on <= 1'b0;
      lang_sel <= 1'b0;
      trig_v_r <= `ISC_LVL_RST;
    end else if (go) begin
      case (op)
        isc_pkg::OP_SETCURR: curr_set <= arg;
        isc_pkg::OP_SETVOLT: volt_set <= arg;
        isc_pkg::OP_SETOCP: ocp_lim <= arg;
        isc_pkg::OP_SETOVP: ovp_lim <= arg;
        isc_pkg::OP_SETOUT: out_on <= arg[0];
        isc_pkg::OP_SETLANG: lang_sel <= arg[0];
        isc_pkg::OP_SETTRIGV: trig_v_r <= arg;
        isc_pkg::OP_RCL: begin
          curr_set <= mem_c[li];
          volt_set <= mem_v[li];
          ovp_lim <= mem_op[li];
          ocp_lim <= mem_oc[li];
          if (mem_sav[li]) begin
            out_on <= mem_out[li];
            lang_sel <= mem_lang[li];
          end
        end
        isc_pkg::OP_RST: begin
          curr_set <= `ISC_LVL_RST;
          volt_set <= `ISC_LVL_RST;
          ocp_lim <= `ISC_OCP_MAX;
          ovp_lim <= `ISC_OVP_MAX;
          out_on <= 1'b0;
        end
        isc_pkg::OP_TRG: begin
          if (trig_armed) begin
            volt_set <= trig_v_r;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_armed <= 1'b0;
    end else if (go & (op == isc_pkg::OP_INIT)) begin
      trig_armed <= 1'b1;
    end else if (go & ((op == isc_pkg::OP_TRG) |
                       (op == isc_pkg::OP_RST))) begin
      trig_armed <= 1'b0;
    end
  end

  // A trip in the same cycle as reset keeps the fault latched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovp_fault <= 1'b0;
      ocp_fault <= 1'b0;
    end else begin
      ovp_fault <= ovp_trip | (ovp_fault & ~(go & (op == isc_pkg::OP_RST)));
      ocp_fault <= ocp_trip | (ocp_fault & ~(go & (op == isc_pkg::OP_RST)));
    end
  end

  // Output settling stands in for pending operations
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_r <= 16'h0000;
    end else if (level_chg) begin
      settle_r <= 16'(SETTLE_CYC);
    end else if (busy) begin
      settle_r <= settle_r - 16'h0001;
    end
  end
  assign busy = (settle_r != 16'h0000);

  // Setup store; list edits mark a location as not saved by command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_r <= 6'h00;
      for (int i = 0; i < NLOC; i++) begin
        mem_c[i] <= 16'h0000;
        mem_v[i] <= 16'h0000;
        mem_op[i] <= 16'h0000;
        mem_oc[i] <= 16'h0000;
        mem_lang[i] <= 1'b0;
        mem_out[i] <= 1'b0;
        mem_sav[i] <= 1'b0;
        mem_par[i] <= 1'b0;
      end
    end else if (go) begin
      case (op)
        isc_pkg::OP_SAV: begin
          mem_c[li] <= curr_set;
          mem_v[li] <= volt_set;
          mem_op[li] <= ovp_lim;
          mem_oc[li] <= ocp_lim;
          mem_lang[li] <= lang_sel;
          mem_out[li] <= out_on;
          mem_sav[li] <= 1'b1;
          mem_par[li] <= par4(curr_set, volt_set, ovp_lim, ocp_lim);
        end
        isc_pkg::OP_LIST_IND: sel_r <= li;
        isc_pkg::OP_LIST_CURR: begin
          mem_c[sel_r] <= arg;
          mem_sav[sel_r] <= 1'b0;
          mem_par[sel_r] <= par4(arg, mem_v[sel_r], mem_op[sel_r],
                                 mem_oc[sel_r]);
        end
        isc_pkg::OP_LIST_VOLT: begin
          mem_v[sel_r] <= arg;
          mem_sav[sel_r] <= 1'b0;
          mem_par[sel_r] <= par4(mem_c[sel_r], arg, mem_op[sel_r],
                                 mem_oc[sel_r]);
        end
        default: begin
        end
      endcase
    end
  end

  // Self-test walks every location and checks its parity
  assign ts_bad = (ts_r == isc_pkg::TS_SCAN) &
    (mem_par[ts_idx_r] != par4(mem_c[ts_idx_r], mem_v[ts_idx_r],
                               mem_op[ts_idx_r], mem_oc[ts_idx_r]));
  assign ts_done = (ts_r == isc_pkg::TS_SCAN) &
                   (ts_idx_r == 6'(NLOC - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_r <= isc_pkg::TS_IDLE;
      ts_idx_r <= 6'h00;
      ts_fail_r <= 1'b0;
    end else begin
      unique case (ts_r)
        isc_pkg::TS_IDLE: begin
          if (go & (op == isc_pkg::OP_TST)) begin
            ts_r <= isc_pkg::TS_SCAN;
            ts_idx_r <= 6'h00;
            ts_fail_r <= 1'b0;
          end
        end
        isc_pkg::TS_SCAN: begin
          ts_fail_r <= ts_fail_r | ts_bad;
          ts_idx_r <= ts_idx_r + 6'h01;
          if (ts_done) begin
            ts_r <= isc_pkg::TS_IDLE;
          end
        end
      endcase
    end
  end

  // Event status; a new event wins over a clearing read
  assign opc_done = opc_armed_r & ~busy;
  always_comb begin
    esr_set = 8'h00;
    esr_set[`ISC_ESR_CME] = cme_set;
    esr_set[`ISC_ESR_EXE] = exe_set;
    esr_set[`ISC_ESR_OPC] = opc_done;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      esr_r <= `ISC_ESR_RST;
      opc_armed_r <= 1'b0;
    end else begin
      if (go & ((op == isc_pkg::OP_ESRQ) | (op == isc_pkg::OP_CLS))) begin
        esr_r <= esr_set;
      end else begin
        esr_r <= esr_r | esr_set;
      end
      opc_armed_r <= (go & (op == isc_pkg::OP_OPC)) |
                     (opc_armed_r & ~opc_done);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ese_r <= 8'h00;
      sre_r <= 8'h00;
    end else if (go & (op == isc_pkg::OP_ESE)) begin
      ese_r <= arg[7:0];
    end else if (go & (op == isc_pkg::OP_SRE)) begin
      sre_r <= arg[7:0] & `ISC_SRE_WMASK;
    end
  end

  isc_mask_or #(.W(8)) u_esb (
    .bits(esr_r),
    .mask(ese_r),
    .any(esb)
  );
  always_comb begin
    stb_base = 8'h00;
    stb_base[`ISC_STB_OPER] = oper_summary;
    stb_base[`ISC_STB_ESB] = esb;
    stb_base[`ISC_STB_MAV] = resp_v_r;
    stb_base[`ISC_STB_QUES] = ques_summary;
  end
  isc_mask_or #(.W(8)) u_mss (
    .bits(stb_base),
    .mask(sre_r),
    .any(mss)
  );
  assign stb = stb_base | {1'b0, mss, 6'h00};
  assign srq = rqs_r;

  // Service request rises with the summary, falls on poll or clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mss_d_r <= 1'b0;
      rqs_r <= 1'b0;
      poll_byte <= 8'h00;
    end else begin
      mss_d_r <= mss;
      rqs_r <= (mss & ~mss_d_r) | (rqs_r & ~serial_poll &
               ~(go & (op == isc_pkg::OP_CLS)));
      if (serial_poll) begin
        poll_byte <= stb_base | {1'b0, rqs_r, 6'h00};
      end
    end
  end

  // Output queue of depth one; a later answer overwrites an unread one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_r <= 16'h0000;
      resp_v_r <= 1'b0;
      opt_act_r <= 1'b0;
      opt_idx_r <= 4'h0;
      opcq_pend_r <= 1'b0;
    end else if (go & (op == isc_pkg::OP_OPT)) begin
      resp_r <= opt_char(4'h0);
      resp_v_r <= 1'b1;
      opt_act_r <= 1'b1;
      opt_idx_r <= 4'h1;
    end else if (go & (op == isc_pkg::OP_OPCQ)) begin
      opcq_pend_r <= 1'b1;
    end else if (go & ((op == isc_pkg::OP_ESEQ) | (op == isc_pkg::OP_ESRQ) |
                 (op == isc_pkg::OP_SREQ) | (op == isc_pkg::OP_STBQ) |
                 (op == isc_pkg::OP_MEASC) | (op == isc_pkg::OP_MEASV))) begin
      resp_v_r <= 1'b1;
      opt_act_r <= 1'b0;
      unique case (op)
        isc_pkg::OP_ESEQ: resp_r <= {8'h00, ese_r};
        isc_pkg::OP_ESRQ: resp_r <= {8'h00, esr_r};
        isc_pkg::OP_SREQ: resp_r <= {8'h00, sre_r};
        isc_pkg::OP_STBQ: resp_r <= {8'h00, stb};
        isc_pkg::OP_MEASC: resp_r <= curr_set;
        default: resp_r <= volt_set;
      endcase
    end else if (opcq_pend_r & ~busy) begin
      resp_r <= `ISC_ASCII_ONE;
      resp_v_r <= 1'b1;
      opcq_pend_r <= 1'b0;
    end else if (ts_done) begin
      resp_r <= {15'h0000, ts_fail_r | ts_bad};
      resp_v_r <= 1'b1;
    end else if (resp_pop) begin
      if (opt_act_r & (opt_idx_r != `ISC_OPT_LEN)) begin
        resp_r <= opt_char(opt_idx_r);
        opt_idx_r <= opt_idx_r + 4'h1;
      end else begin
        resp_v_r <= 1'b0;
        opt_act_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ahb_take & ~hwrite) begin
      case (haddr[7:0])
        `ISC_A_RESP: hrdata <= {15'h0000, resp_v_r, resp_r};
        `ISC_A_STAT: hrdata <= {24'h00_0000, trig_armed, ocp_fault,
          ovp_fault, lang_sel, out_on, ts_r == isc_pkg::TS_SCAN, busy,
          resp_v_r};
        `ISC_A_LVL: hrdata <= {volt_set, curr_set};
        `ISC_A_LIM: hrdata <= {ovp_lim, ocp_lim};
        `ISC_A_STB: hrdata <= {24'h00_0000, stb};
        `ISC_A_TRIG: hrdata <= {10'h000, sel_r, trig_v_r};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_rst_levels: assert property (go && op == isc_pkg::OP_RST |=>
    curr_set == 16'h0000 && volt_set == 16'h0000 &&
    ocp_lim == 16'hFFFF && !out_on)
    else $error("reset did not restore defaults");
  chk_rst_fault: assert property (go && op == isc_pkg::OP_RST &&
    !ovp_trip && !ocp_trip |=> !ovp_fault && !ocp_fault)
    else $error("fault survived reset");
  chk_unknown_cme: assert property (cmd_wr && !known |=>
    esr_r[5]) else $error("unknown header left command error clear");
  chk_esr_read: assert property (go && op == isc_pkg::OP_ESRQ &&
    esr_set == 8'h00 |=> esr_r == 8'h00 && resp_r == {8'h00, $past(esr_r)})
    else $error("event status read wrong or not cleared");
  chk_bad_loc: assert property (cmd_wr && op == isc_pkg::OP_RCL &&
    !loc_ok |=> $stable(curr_set) && $stable(volt_set) && esr_r[4])
    else $error("bad location changed settings");
  chk_local_hold: assert property (
    cmd_wr && !(remote_mode && ren) &&
    (op == isc_pkg::OP_SETVOLT || op == isc_pkg::OP_SETCURR) |=>
    $stable(volt_set) && $stable(curr_set))
    else $error("local mode accepted a setting");
  chk_trg_volt: assert property (go && op == isc_pkg::OP_TRG &&
    trig_armed |=> volt_set == $past(trig_v_r) && !trig_armed)
    else $error("trigger did not move voltage");
  chk_opcq_idle: assert property ($fell(opcq_pend_r) |->
    !$past(busy) && resp_v_r && resp_r == 16'h0031)
    else $error("completion answer while busy");
  chk_esb_sum: assert property (stb[5] == |(esr_r & ese_r))
    else $error("event summary mismatch");
  chk_poll_rqs: assert property (
    serial_poll && !(mss && !mss_d_r) |=> !rqs_r)
    else $error("poll left service request set");
  chk_sre_bit6: assert property (go && op == isc_pkg::OP_SRE |=>
    !sre_r[6]) else $error("bit 6 of service mask writable");
endmodule

//--- tb/isc_ctl_model.sv
// Bus controller model: an AHB-Lite master that issues single word
// transfers. Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/10ps
module isc_ctl_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  int timeouts = 0;
  initial begin
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // Holds each phase until hready is seen high; a bounded wait so a dead
  // slave cannot hang the run
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge hclk);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) begin
      timeouts++;
    end
  endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench of the command handler, driven by command words.
// Assumes the controller model as sole bus master, short settle count.
`timescale 1ns/10ps
module testbench;
  localparam logic [119:0] OPT_STR =
    120'h43_414C_2C52_4C33_2C4D_3430_2C44_3136;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic remote_mode = 1'b1;
  logic ren = 1'b1;
  logic serial_poll = 1'b0;
  logic ovp_trip = 1'b0;
  logic ocp_trip = 1'b0;
  logic ques_summary = 1'b0;
  logic oper_summary = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] curr_set, volt_set, ocp_lim, ovp_lim;
  logic out_on, lang_sel, ovp_fault, ocp_fault, trig_armed, srq;
  logic [7:0] poll_byte;
  int mismatches = 0;
  int n_checks = 0;
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  isc_ctl_model i_isc_ctl_model (.hclk, .hready, .hrdata, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata);
  isc_cmd_handler #(.SETTLE_CYC(20)) i_isc_cmd_handler (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .remote_mode, .ren, .serial_poll, .ovp_trip,
    .ocp_trip, .ques_summary, .oper_summary, .curr_set, .volt_set,
    .ocp_lim, .ovp_lim, .out_on, .lang_sel, .ovp_fault, .ocp_fault,
    .trig_armed, .srq, .poll_byte);
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    mismatches += i_isc_ctl_model.timeouts;
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Idle edges after each command: a read right behind it already sees the new state
  task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
    logic [31:0] q;
    i_isc_ctl_model.xfer(1'b1, 8'h00, {8'h00, arg, op}, q);
    repeat (2) @(posedge hclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    i_isc_ctl_model.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic ans(input string nm, input logic [15:0] e);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(8'h04, q);
      n++;
    end while (q[16] !== 1'b1 && n < 200);
    chk(nm, {16'h0001, e}, q);
  endtask
  task automatic qry(input logic [7:0] op, input logic [15:0] e,
                     input string nm);
    cmd(op, 16'h0000);
    ans(nm, e);
  endtask
  initial begin
    repeat (50000) @(posedge hclk);
    mismatches++;
    close_out();
  end
  initial begin
    logic [31:0] q;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h40, q);
    chk("unmapped", 32'h0000_0000, q);
    chk("hresp", 32'h0000_0000, hresp);
    qry(isc_pkg::OP_ESRQ, 16'h0080, "esr_pon");
    qry(isc_pkg::OP_ESRQ, 16'h0000, "esr_clr");
    cmd(8'h3F, 16'h0000);
    qry(isc_pkg::OP_ESRQ, 16'h0020, "esr_cme");
    cmd(isc_pkg::OP_ESE, 16'h003C);
    qry(isc_pkg::OP_ESEQ, 16'h003C, "ese");
    cmd(8'h3F, 16'h0000);
    cmd(isc_pkg::OP_SRE, 16'h0068);
    qry(isc_pkg::OP_SREQ, 16'h0028, "sre");
    qry(isc_pkg::OP_STBQ, 16'h0060, "stbq");
    rd(8'h14, q);
    chk("stb", 32'h0000_0060, q);
    chk("srq", 32'h0000_0001, srq);
    serial_poll <= 1'b1;
    @(posedge hclk);
    serial_poll <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("srq_poll", 32'h0000_0000, srq);
    chk("poll_byte", 32'h0000_0060, poll_byte);
    rd(8'h14, q);
    chk("stb_kept", 32'h0000_0060, q);
    cmd(isc_pkg::OP_CLS, 16'h0000);
    rd(8'h14, q);
    chk("stb_zero", 32'h0000_0000, q);
    cmd(isc_pkg::OP_SETCURR, 16'h1234);
    cmd(isc_pkg::OP_SETVOLT, 16'h2345);
    cmd(isc_pkg::OP_SETOCP, 16'h0AAA);
    cmd(isc_pkg::OP_SETOVP, 16'h0BBB);
    cmd(isc_pkg::OP_SETOUT, 16'h0001);
    cmd(isc_pkg::OP_SETLANG, 16'h0001);
    cmd(isc_pkg::OP_SAV, 16'd33);
    cmd(isc_pkg::OP_SETCURR, 16'h0005);
    cmd(isc_pkg::OP_SETVOLT, 16'h0006);
    cmd(isc_pkg::OP_SETOUT, 16'h0000);
    cmd(isc_pkg::OP_SETLANG, 16'h0000);
    cmd(isc_pkg::OP_RCL, 16'd33);
    chk("lvl", 32'h1234_2345, {curr_set, volt_set});
    chk("lim", 32'h0AAA_0BBB, {ocp_lim, ovp_lim});
    chk("mode", 32'h0000_0003, {out_on, lang_sel});
    rd(8'h0C, q);
    chk("lvl_bus", 32'h2345_1234, q);
    cmd(isc_pkg::OP_LIST_IND, 16'd21);
    cmd(isc_pkg::OP_LIST_CURR, 16'h00EB);
    cmd(isc_pkg::OP_LIST_VOLT, 16'h00E0);
    cmd(isc_pkg::OP_RCL, 16'd21);
    chk("lvl21", 32'h00EB_00E0, {curr_set, volt_set});
    chk("mode21", 32'h0000_0003, {out_on, lang_sel});
    cmd(isc_pkg::OP_SAV, 16'd41);
    cmd(isc_pkg::OP_RCL, 16'd0);
    qry(isc_pkg::OP_ESRQ, 16'h0010, "esr_range");
    chk("lvl_kept", 32'h00EB_00E0, {curr_set, volt_set});
    ren <= 1'b0;
    cmd(isc_pkg::OP_SETCURR, 16'h0777);
    qry(isc_pkg::OP_MEASC, 16'h00EB, "meas_local");
    qry(isc_pkg::OP_MEASV, 16'h00E0, "measv_local");
    ren <= 1'b1;
    remote_mode <= 1'b0;
    cmd(isc_pkg::OP_SETVOLT, 16'h0777);
    remote_mode <= 1'b1;
    chk("volt_local", 32'h0000_00E0, volt_set);
    qry(isc_pkg::OP_ESRQ, 16'h0010, "esr_local");
    cmd(isc_pkg::OP_SETTRIGV, 16'h000C);
    cmd(isc_pkg::OP_INIT, 16'h0000);
    rd(8'h08, q);
    chk("armed", 32'h0000_0098, q);
    cmd(isc_pkg::OP_TRG, 16'h0000);
    chk("trig", 32'h0000_000C, volt_set);
    chk("disarm", 32'h0000_0000, trig_armed);
    ovp_trip <= 1'b1;
    ocp_trip <= 1'b1;
    @(posedge hclk);
    ovp_trip <= 1'b0;
    ocp_trip <= 1'b0;
    @(posedge hclk);
    chk("faults", 32'h0000_0003, {ovp_fault, ocp_fault});
    cmd(isc_pkg::OP_RST, 16'h0000);
    chk("rst_lvl", 32'h0000_0000, {curr_set, volt_set});
    chk("rst_lim", 32'hFFFF_FFFF, {ocp_lim, ovp_lim});
    chk("rst_out", 32'h0000_0000, out_on);
    chk("rst_flt", 32'h0000_0000, {ovp_fault, ocp_fault});
    cmd(isc_pkg::OP_SETVOLT, 16'h0015);
    cmd(isc_pkg::OP_OPC, 16'h0000);
    repeat (30) @(posedge hclk);
    qry(isc_pkg::OP_ESRQ, 16'h0001, "esr_opc");
    cmd(isc_pkg::OP_SETVOLT, 16'h0016);
    cmd(isc_pkg::OP_OPCQ, 16'h0000);
    rd(8'h04, q);
    chk("opcq_wait", 32'h0000_0000, q[16]);
    ans("opcq", 16'h0031);
    qry(isc_pkg::OP_TST, 16'h0000, "tst");
    cmd(isc_pkg::OP_OPT, 16'h0000);
    for (int i = 0; i < 15; i++) begin
      ans("opt", {8'h00, OPT_STR[119-8*i -: 8]});
    end
    rd(8'h04, q);
    chk("opt_end", 32'h0000_0000, q[16]);
    close_out();
  end
endmodule
